//--- hw/sec_pkg.sv
package sec_pkg;
  // Register byte addresses
  localparam logic [15:0] SEC_ADDR_RSRC  = 16'hFE01;
  localparam logic [15:0] SEC_ADDR_BEXIT = 16'hFE00;
  localparam logic [15:0] SEC_ADDR_BFCC  = 16'hFE03;
  // Reset-source field positions
  localparam int SEC_RS_POR   = 7;
  localparam int SEC_RS_PIN   = 6;
  localparam int SEC_RS_WDOG  = 5;
  localparam int SEC_RS_BOP   = 4;
  localparam int SEC_RS_BADR  = 3;
  localparam int SEC_RS_MON   = 2;
  localparam int SEC_RS_LVF   = 1;
  localparam logic [7:0] SEC_RSRC_RESET = 8'h80;
  localparam logic [7:0] SEC_RSRC_MASK  = 8'hFE;
  localparam int SEC_BEXIT_BIT = 1;
  localparam int SEC_BCE_BIT   = 7;
  // Stop recovery in crystal clock cycles
  localparam int SEC_STOP_RECOVERY_CYC = 4096;
  localparam int SEC_NUM_IRQ = 8;
  typedef enum logic [4:0] {
    SEC_RUN    = 5'h01,
    SEC_STACK  = 5'h02,
    SEC_WAIT   = 5'h04,
    SEC_STOP   = 5'h08,
    SEC_RECOV  = 5'h10
  } sec_state_t;
endpackage

//--- hw/sec_exception_unit.sv
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module sec_exception_unit #(
  parameter int NUM_IRQ      = sec_pkg::SEC_NUM_IRQ,
  parameter int STOP_RECOVERY = sec_pkg::SEC_STOP_RECOVERY_CYC,
  parameter int PRESC_W      = 13
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // Register port
  input  wire logic [15:0]          reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [7:0]           reg_rdata,
  // Reset source capture, sampled on the reset release cycle
  input  wire logic                 src_power_on,
  input  wire logic                 src_pin,
  input  wire logic                 src_watchdog,
  input  wire logic                 src_bad_opcode,
  input  wire logic                 src_bad_fetch,
  input  wire logic                 src_monitor,
  input  wire logic                 src_low_voltage,
  // Core handshake
  input  wire logic [NUM_IRQ-1:0]   irq_req,
  input  wire logic [NUM_IRQ-1:0]   irq_en,
  input  wire logic                 cpu_mask,
  input  wire logic                 cpu_insn_end,
  input  wire logic                 cpu_trap,
  input  wire logic                 cpu_return,
  input  wire logic                 cpu_wait,
  input  wire logic                 cpu_stop,
  input  wire logic                 cpu_stack_done,
  input  wire logic                 cpu_fetch_opcode,
  input  wire logic                 cpu_fetch_bad,
  input  wire logic                 brk_state,
  input  wire logic                 brk_req,
  input  wire logic                 watchdog_disable_bit,
  output logic                      int_start,
  output logic                      int_active,
  output logic [7:0]                int_vector_code,
  output logic                      push_regs,
  output logic                      push_upper_index,
  output logic                      set_mask,
  output logic                      clear_mask,
  output logic                      restore_regs,
  output logic                      discard_prefetch,
  output logic                      cpu_clk_en,
  output logic                      periph_clk_en,
  output logic                      osc_clk_en,
  output logic                      watchdog_run,
  output logic                      prescaler_clear,
  output logic                      bad_fetch_reset,
  output logic [PRESC_W-1:0]        prescaler
);
  import sec_pkg::*;

  localparam int RCW = $clog2(STOP_RECOVERY + 1);

  sec_state_t           state_reg;
  logic [NUM_IRQ-1:0]   latched_reg;
  logic                 trap_reg;
  logic [RCW-1:0]       recov_reg;
  logic [7:0]           rsrc_reg;
  logic                 bexit_reg;
  logic                 bce_reg;
  logic                 rel_reg;
  logic [7:0]           rdata_next;
  logic [NUM_IRQ-1:0]   pend;
  logic [7:0]           win_code;
  logic                 win_any;
  logic                 can_clear;
  logic                 rd_rsrc;

  assign pend      = irq_req & irq_en;
  assign can_clear = !brk_state || bce_reg;
  assign rd_rsrc   = reg_rd && reg_addr == SEC_ADDR_RSRC;

  // Lowest index has the highest priority
  always_comb begin
    win_code = 8'h00;
    win_any  = 1'b0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (pend[i]) begin
        win_code = 8'(i + 1);
        win_any  = 1'b1;
      end
    end
  end

  // Exception sequencer; reset overrides everything via sys_rst
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= SEC_RUN;
    end else begin
      case (state_reg)
        SEC_RUN: begin
          // Only evaluated at instruction end
          if (cpu_insn_end && (cpu_trap || (!cpu_mask && win_any))) begin
            state_reg <= SEC_STACK;
          end else if (cpu_insn_end && cpu_wait) begin
            state_reg <= SEC_WAIT;
          end else if (cpu_insn_end && cpu_stop) begin
            state_reg <= SEC_STOP;
          end
        end
        SEC_STACK: begin
          if (cpu_stack_done) begin
            state_reg <= SEC_RUN;
          end
        end
        SEC_WAIT: begin
          // Mask was cleared on entry, so any enabled request wakes
          if (win_any || brk_req) begin
            state_reg <= SEC_STACK;
          end
        end
        SEC_STOP: begin
          if (win_any || brk_req) begin
            state_reg <= SEC_RECOV;
          end
        end
        SEC_RECOV: begin
          if (recov_reg == RCW'(STOP_RECOVERY - 1)) begin
            state_reg <= SEC_STACK;
          end
        end
        default: state_reg <= SEC_RUN;
      endcase
    end
  end

  // Request latch; frozen once taken so nothing displaces it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      latched_reg <= '0;
      trap_reg    <= 1'b0;
    end else if (state_reg == SEC_STACK) begin
      if (cpu_stack_done) begin
        latched_reg <= '0;
        trap_reg    <= 1'b0;
      end
    end else if (int_start) begin
      latched_reg <= pend;
      trap_reg    <= cpu_trap && state_reg == SEC_RUN;
    end else if (!cpu_mask && !cpu_trap && state_reg == SEC_RUN) begin
      latched_reg <= '0;
    end
  end

  // Vector code held at latch time: 8'hFF for a trap taken in run, else the winning request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_vector_code <= 8'h00;
    end else if (int_start) begin
      int_vector_code <= (cpu_trap && state_reg == SEC_RUN) ? 8'hFF : win_code;
    end
  end

  always_comb begin
    int_start = 1'b0;
    case (state_reg)
      SEC_RUN:   int_start = cpu_insn_end && (cpu_trap || (!cpu_mask && win_any));
      SEC_WAIT:  int_start = win_any || brk_req;
      SEC_RECOV: int_start = recov_reg == RCW'(STOP_RECOVERY - 1);
      default:   int_start = 1'b0;
    endcase
  end

  assign int_active       = state_reg == SEC_STACK;
  assign push_regs        = state_reg == SEC_STACK && !cpu_stack_done;
  assign set_mask         = state_reg == SEC_STACK && cpu_stack_done;
  assign push_upper_index = 1'b0;
  assign restore_regs     = state_reg == SEC_RUN && cpu_return;
  // Return with something still pending: the fetched opcode is thrown away
  assign discard_prefetch = restore_regs && win_any;
  assign clear_mask       = state_reg == SEC_RUN && cpu_insn_end && cpu_wait;
  assign cpu_clk_en       = state_reg == SEC_RUN || state_reg == SEC_STACK;
  assign periph_clk_en    = state_reg != SEC_STOP && state_reg != SEC_RECOV;
  // Oscillator restarts for recovery so the delay can be counted
  assign osc_clk_en       = state_reg != SEC_STOP;
  assign watchdog_run     = !watchdog_disable_bit && osc_clk_en;
  assign prescaler_clear  = state_reg == SEC_STOP;
  assign bad_fetch_reset  = cpu_fetch_opcode && cpu_fetch_bad;

  // Stop recovery counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      recov_reg <= '0;
    end else if (state_reg == SEC_RECOV) begin
      recov_reg <= recov_reg + RCW'(1);
    end else begin
      recov_reg <= '0;
    end
  end

  // Prescaler counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prescaler <= '0;
    end else if (prescaler_clear) begin
      prescaler <= '0;
    end else begin
      prescaler <= prescaler + PRESC_W'(1);
    end
  end

  // Release marker: sources are caught by a clock, not by the reset itself
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rel_reg <= 1'b1;
    end else begin
      rel_reg <= 1'b0;
    end
  end

  // Reset source flags
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsrc_reg <= SEC_RSRC_RESET;
    end else if (rel_reg) begin
      if (src_power_on) begin
        rsrc_reg <= SEC_RSRC_RESET;
      end else begin
        rsrc_reg                <= 8'h00;
        rsrc_reg[SEC_RS_PIN]    <= src_pin;
        rsrc_reg[SEC_RS_WDOG]   <= src_watchdog;
        rsrc_reg[SEC_RS_BOP]    <= src_bad_opcode;
        rsrc_reg[SEC_RS_BADR]   <= src_bad_fetch;
        rsrc_reg[SEC_RS_MON]    <= src_monitor;
        rsrc_reg[SEC_RS_LVF]    <= src_low_voltage;
      end
    end else if (rd_rsrc && can_clear) begin
      rsrc_reg <= 8'h00;
    end
  end

  // Break exit flag; set wins over a clearing write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bexit_reg <= 1'b0;
    end else if (state_reg == SEC_WAIT && brk_req) begin
      bexit_reg <= 1'b1;
    end else if (reg_wr && reg_addr == SEC_ADDR_BEXIT && !reg_wdata[SEC_BEXIT_BIT]
                 && can_clear) begin
      bexit_reg <= 1'b0;
    end
  end

  // Break clear enable
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bce_reg <= 1'b0;
    end else if (reg_wr && reg_addr == SEC_ADDR_BFCC) begin
      bce_reg <= reg_wdata[SEC_BCE_BIT];
    end
  end

  // Read mux; unmapped reads return zero
  always_comb begin
    rdata_next = 8'h00;
    if (reg_addr == SEC_ADDR_RSRC) begin
      rdata_next = rsrc_reg & SEC_RSRC_MASK;
    end else if (reg_addr == SEC_ADDR_BEXIT) begin
      rdata_next[SEC_BEXIT_BIT] = bexit_reg;
    end else if (reg_addr == SEC_ADDR_BFCC) begin
      rdata_next[SEC_BCE_BIT] = bce_reg;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

//--- bench/sec_exception_props.sv
`timescale 1ns/1ps
module sec_exception_props #(
  parameter int NUM_IRQ = 8,
  parameter int PRESC_W = 13
) (
  // Clock and reset
  input wire logic               clk,
  input wire logic               sys_rst,
  // Core side inputs
  input wire logic [NUM_IRQ-1:0] irq_req,
  input wire logic [NUM_IRQ-1:0] irq_en,
  input wire logic               cpu_mask,
  input wire logic               cpu_insn_end,
  input wire logic               cpu_trap,
  input wire logic               cpu_wait,
  input wire logic               cpu_stack_done,
  input wire logic               watchdog_disable_bit,
  // Block outputs
  input wire logic               int_start,
  input wire logic               int_active,
  input wire logic [7:0]         int_vector_code,
  input wire logic               push_upper_index,
  input wire logic               set_mask,
  input wire logic               clear_mask,
  input wire logic               cpu_clk_en,
  input wire logic               periph_clk_en,
  input wire logic               osc_clk_en,
  input wire logic               watchdog_run,
  input wire logic               prescaler_clear,
  input wire logic [PRESC_W-1:0] prescaler
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_no_upper_push: assert property (!push_upper_index)
    else $error("upper index pushed");
  chk_mask_on_done: assert property (int_active && cpu_stack_done |-> set_mask)
    else $error("mask not set after stacking");
  chk_start_then_stack: assert property (int_start |=> int_active && cpu_clk_en)
    else $error("stacking did not follow start");
  chk_start_cause: assert property (int_start && cpu_clk_en && !int_active |-> cpu_insn_end
    && (cpu_trap || !cpu_mask && (irq_req & irq_en) != '0)) else $error("start without cause");
  chk_trap_taken: assert property (cpu_insn_end && cpu_trap && cpu_clk_en && !int_active
    |-> int_start ##1 int_vector_code == 8'hFF) else $error("trap not taken");
  chk_wait_entry: assert property (cpu_insn_end && cpu_wait && cpu_clk_en && !int_active
    && !int_start |-> clear_mask ##1 !cpu_clk_en && periph_clk_en) else $error("bad wait entry");
  chk_stop_gates: assert property (prescaler_clear |-> !osc_clk_en && !periph_clk_en)
    else $error("clocks run in stop");
  chk_presc_held: assert property (prescaler_clear [*2] |-> prescaler == '0)
    else $error("prescaler not cleared");
  chk_wdog_run: assert property (watchdog_run == (!watchdog_disable_bit && osc_clk_en))
    else $error("watchdog run wrong");
endmodule

bind sec_exception_unit sec_exception_props #(.NUM_IRQ(NUM_IRQ), .PRESC_W(PRESC_W)) u_props (.*);

//--- bench/sec_core_model.sv
`timescale 1ns/1ps
module sec_core_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Stacking handshake
  input  wire logic       int_active,
  input  wire logic [3:0] stack_len,
  output logic            cpu_stack_done
);
  logic [3:0] cnt_reg;
  // Pushes take stack_len+1 cycles, upper index byte left out
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg        <= 4'h0;
      cpu_stack_done <= 1'b0;
    end else if (int_active && !cpu_stack_done) begin
      cnt_reg        <= cnt_reg + 4'h1;
      cpu_stack_done <= (cnt_reg == stack_len);
    end else begin
      cnt_reg        <= 4'h0;
      cpu_stack_done <= 1'b0;
    end
  end
endmodule

//--- bench/sec_exception_unit_tb_top.sv
`timescale 1ns/1ps
module sec_exception_unit_tb_top;
  import sec_pkg::*;
  logic        clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00, irq_req = 8'h00, irq_en = 8'hFF, reg_rdata, int_vector_code;
  logic [6:0]  src_v = 7'h40;
  logic [3:0]  stack_len = 4'h2;
  logic        cpu_mask = 1'b0, cpu_insn_end = 1'b0, cpu_trap = 1'b0, cpu_return = 1'b0;
  logic        cpu_wait = 1'b0, cpu_stop = 1'b0, cpu_fetch_opcode = 1'b0, cpu_fetch_bad = 1'b0;
  logic        brk_state = 1'b0, brk_req = 1'b0, watchdog_disable_bit = 1'b0, cpu_stack_done;
  logic        int_start, int_active, push_regs, push_upper_index, set_mask, clear_mask;
  logic        restore_regs, discard_prefetch, cpu_clk_en, periph_clk_en, osc_clk_en;
  logic        watchdog_run, prescaler_clear, bad_fetch_reset;
  logic [12:0] prescaler;
  logic [7:0]  v;
  int          n_mismatch = 0, total_checks = 0, cyc = 0, k;

  sec_exception_unit #(.STOP_RECOVERY(8)) dut (.*, .src_power_on(src_v[6]), .src_pin(src_v[5]),
    .src_watchdog(src_v[4]), .src_bad_opcode(src_v[3]), .src_bad_fetch(src_v[2]),
    .src_monitor(src_v[1]), .src_low_voltage(src_v[0]));
  sec_core_model model (.clk, .sys_rst, .int_active, .stack_len, .cpu_stack_done);

  always #12.5 clk = ~clk;
  // Whole run is under two hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_reset(input logic [6:0] s);
    sys_rst <= 1'b1;
    src_v <= s;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    src_v <= 7'h00;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // One instruction end; int_start and clear_mask judged in that cycle
  task automatic insn(input logic t, w, s, es);
    {cpu_trap, cpu_wait, cpu_stop, cpu_insn_end} <= {t, w, s, 1'b1};
    #2 chk(int_start, es);
    chk(clear_mask, w & ~es);
    @(posedge clk);
    {cpu_trap, cpu_wait, cpu_stop, cpu_insn_end} <= 4'h0;
  endtask
  // Bounded wait for a whole stacking sequence, last vector code kept
  task automatic serve();
    for (k = 0; int_active !== 1'b1 && k < 30; k++) @(posedge clk) #1;
    for (; int_active !== 1'b0 && k < 60; k++) begin
      v = int_vector_code;
      @(posedge clk) #1;
    end
    chk(k < 60, 1'b1);
  endtask

  task automatic t_src();
    for (int i = 0; i < 7; i++) begin
      do_reset(7'h01 << i);
      rd(SEC_ADDR_RSRC, (i == 6) ? 8'h80 : 8'h02 << i);
    end
    do_reset(7'h7F);
    rd(SEC_ADDR_RSRC, 8'h80);
    rd(SEC_ADDR_RSRC, 8'h00);
    do_reset(7'h20);
    wr(SEC_ADDR_RSRC, 8'hFF);
    wr(SEC_ADDR_BFCC, 8'h00);
    brk_state <= 1'b1;
    rd(SEC_ADDR_RSRC, 8'h40);
    rd(SEC_ADDR_RSRC, 8'h40);
    wr(SEC_ADDR_BFCC, 8'h80);
    rd(SEC_ADDR_RSRC, 8'h40);
    rd(SEC_ADDR_RSRC, 8'h00);
    brk_state <= 1'b0;
    rd(16'h1234, 8'h00);
    cpu_fetch_bad <= 1'b1;
    #2 chk(bad_fetch_reset, 1'b0);
    cpu_fetch_opcode <= 1'b1;
    #2 chk(bad_fetch_reset, 1'b1);
    $display("t_src done");
  endtask
  task automatic t_irq();
    irq_req <= 8'h14;
    insn(1'b0, 1'b0, 1'b0, 1'b1);
    irq_req <= 8'h15;
    serve();
    chk(v, 8'h03);
    cpu_return <= 1'b1;
    #2 chk({restore_regs, discard_prefetch}, 2'b11);
    @(posedge clk);
    cpu_return <= 1'b0;
    insn(1'b0, 1'b0, 1'b0, 1'b1);
    serve();
    chk(v, 8'h01);
    cpu_mask <= 1'b1;
    insn(1'b0, 1'b0, 1'b0, 1'b0);
    insn(1'b1, 1'b0, 1'b0, 1'b1);
    serve();
    chk(v, 8'hFF);
    {cpu_mask, irq_en} <= 9'h000;
    insn(1'b0, 1'b0, 1'b0, 1'b0);
    {irq_req, irq_en} <= 16'h00FF;
    $display("t_irq done");
  endtask
  task automatic t_wait();
    insn(1'b0, 1'b1, 1'b0, 1'b0);
    #1 chk({cpu_clk_en, periph_clk_en, watchdog_run}, 3'b011);
    irq_req <= 8'h08;
    #2 chk(int_start, 1'b1);
    @(posedge clk) #1 chk(int_active, 1'b1);
    serve();
    chk(v, 8'h04);
    irq_req <= 8'h00;
    insn(1'b0, 1'b1, 1'b0, 1'b0);
    brk_req <= 1'b1;
    @(posedge clk);
    brk_req <= 1'b0;
    serve();
    rd(SEC_ADDR_BEXIT, 8'h02);
    wr(SEC_ADDR_BEXIT, 8'h00);
    rd(SEC_ADDR_BEXIT, 8'h00);
    insn(1'b0, 1'b1, 1'b0, 1'b0);
    do_reset(7'h20);
    chk(cpu_clk_en, 1'b1);
    $display("t_wait done");
  endtask
  task automatic t_stop();
    insn(1'b0, 1'b0, 1'b1, 1'b0);
    @(posedge clk) #1 chk({osc_clk_en, prescaler_clear, prescaler}, 15'h2000);
    watchdog_disable_bit <= 1'b1;
    irq_req <= 8'h01;
    for (k = 0; int_active !== 1'b1 && k < 30; k++) @(posedge clk) #1;
    chk(k >= 9 && k <= 10, 1'b1);
    chk(watchdog_run, 1'b0);
    irq_req <= 8'h00;
    serve();
    $display("t_stop done");
  endtask

  initial begin
    do_reset(7'h40);
    t_src();
    t_irq();
    t_wait();
    t_stop();
    summarize();
  end
endmodule
